// >>> ddr_port_map.svh
`ifndef DDR_PORT_MAP_SVH
`define DDR_PORT_MAP_SVH

// Array geometry of the by-36 organisation.
`define ADDR_W 19
`define DATA_W 36
`define LANE_W 9
`define LANES 4
`define WORDS_PER_BURST 2

// Write buffer between the pin capture and the array.
`define WBUF_DEPTH 16

// Reset values of the filtered pin image and the data outputs.
`define LOAD_IDLE 1'b1
`define DQ_RESET 36'h0_0000_0000
`define OE_N_RESET 1'b1

`endif

// >>> ddr_port_pkg.sv
`include "ddr_port_map.svh"

package ddr_port_pkg;

    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef logic [`LANES-1:0] lane_t;

    // One burst word on its way into the array.
    typedef struct packed {
        addr_t addr;
        data_t data;
        lane_t lane_n;
    } wr_word_s;

    // Image of every pin that comes from the memory controller.
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic single_clock_mode;
        logic cycle_load_n;
        logic read_write;
        addr_t addr;
        lane_t lane_n;
        data_t dq;
    } pins_s;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_FIRST,
        RD_SECOND,
        RD_HOLD
    } rd_state_e;

    typedef enum logic [1:0] {
        WR_IDLE,
        WR_FIRST,
        WR_SECOND
    } wr_state_e;

endpackage : ddr_port_pkg

// >>> sync_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW:0] wr_ptr_q;
    logic [PW:0] rd_ptr_q;
    logic full;
    logic empty;

    // Pointers carry one extra bit so full and empty are told apart.
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full = (wr_ptr_q[PW] != rd_ptr_q[PW]) &&
                  (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = store[rd_ptr_q[PW-1:0]];

    // Storage is written only on an accepted push.
    always_ff @(posedge core_clk) begin
        if (in_valid && in_ready) begin
            store[wr_ptr_q[PW-1:0]] <= in_data;
        end
    end

    // Write pointer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_q <= '0;
        end else if (in_valid && in_ready) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // Read pointer.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_ptr_q <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

endmodule : sync_fifo

`default_nettype wire

// >>> ddr_burst2_sram_port.sv
// Overview of operation
// [R1] Write data is taken on rising true and complement input clock edges.
// [R2] Read words go out on output clock edges, or input clocks in single mode.
// [R3] Data outputs float whenever no read burst is being driven.
// [R4] The controller pulls the load strobe low to define each bus cycle.
// [R5] Every read or write moves exactly two words as one burst.
// [R6] Active-low lane selects each guard one 9-bit lane of the word.
// [R7] Each lane select is sampled on the same edge as its data word.
// [R8] A deasserted lane select leaves the stored lane unchanged.
// [R9] One shared address bus serves both reads and writes.
// [R10] The burst LSB loads a one-bit counter that steps to the second word.
// [R11] The address is 19 bits wide, the burst LSB included.
// [R12] Address inputs are ignored on cycles without the load strobe.
// [R13] With load low, read_write high requests a read, low a write.
// [R14] Every access starts on the true input clock rising edge.
// [R15] First word at loaded address, second at inverted burst LSB.
`timescale 1ns/1ps
`default_nettype none
`include "ddr_port_map.svh"

module ddr_burst2_sram_port (
    // Core clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Input and output clocks from the controller.
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    // Command and address.
    input wire logic cycle_load_n,
    input wire logic read_write,
    input wire logic [`ADDR_W-2:0] addr_hi,
    input wire logic burst_lsb_addr,
    // Write data and lane selects.
    input wire logic [`LANES-1:0] lane_write_enable_n,
    // Two-way data pins.
    input wire logic [`DATA_W-1:0] dq_in,
    output logic [`DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    // Write buffer state.
    output logic write_buffer_full
);

    import ddr_port_pkg::*;

    // Rising edge of a filtered pin between two core clock samples.
    function automatic logic rose(input logic prev, input logic cur);
        rose = !prev && cur;
    endfunction : rose

    // Address of the second burst word: the burst counter steps once.
    function automatic addr_t next_in_burst(input addr_t a);
        next_in_burst = {a[`ADDR_W-1:1], ~a[0]};
    endfunction : next_in_burst

    pins_s pins_raw;
    pins_s s1_q;
    pins_s s2_q;
    pins_s s3_q;
    pins_s f_q;
    pins_s prev_q;

    logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];

    logic k_rise;
    logic kn_rise;
    logic out_true_rise;
    logic out_comp_rise;
    logic load_read;
    logic load_write;

    rd_state_e rd_state_q;
    wr_state_e wr_state_q;
    addr_t rd_addr_q;
    addr_t wr_addr_q;
    logic [1:0] fetch_q;
    data_t rd_word0_q;
    data_t rd_word1_q;

    wr_word_s push_word;
    logic push_valid;
    logic push_ready;
    wr_word_s drain_word;
    logic drain_valid;
    logic drain_ready;

    // All pins are gathered so that data and clocks see equal delay.
    assign pins_raw = '{
        k: k_clk,
        k_n: k_clk_n,
        c: c_clk,
        c_n: c_clk_n,
        single_clock_mode: single_clock_mode,
        cycle_load_n: cycle_load_n,
        read_write: read_write,
        addr: {addr_hi, burst_lsb_addr}, // [R9] [R11]
        lane_n: lane_write_enable_n,
        dq: dq_in
    };

    // Idle pin image: clocks low, load high, every lane deselected.
    localparam pins_s PINS_IDLE = '{
        k: 1'b0,
        k_n: 1'b0,
        c: 1'b0,
        c_n: 1'b0,
        single_clock_mode: 1'b0,
        cycle_load_n: `LOAD_IDLE,
        read_write: 1'b0,
        addr: '0,
        lane_n: '1,
        dq: `DQ_RESET
    };

    // Three-stage synchroniser; the first stage feeds only the second.
    // Stages reset to the idle image so no false load follows reset.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_q <= PINS_IDLE;
            s2_q <= PINS_IDLE;
            s3_q <= PINS_IDLE;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A pin change is accepted once the second and third stages agree.
    // Filtering per bit keeps a slow data pin from holding back a clock.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            f_q <= PINS_IDLE;
            prev_q <= PINS_IDLE;
        end else begin
            f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
            prev_q <= f_q;
        end
    end

    // Edge events of the input clocks and the selected output clocks.
    assign k_rise = rose(prev_q.k, f_q.k);
    assign kn_rise = rose(prev_q.k_n, f_q.k_n);
    assign out_true_rise = f_q.single_clock_mode ? k_rise :
                           rose(prev_q.c, f_q.c); // [R2]
    assign out_comp_rise = f_q.single_clock_mode ? kn_rise :
                           rose(prev_q.c_n, f_q.c_n); // [R2]

    // Commands are decoded only on a true clock edge with load low.
    assign load_read = k_rise && !f_q.cycle_load_n &&
                       f_q.read_write; // [R4] [R13] [R14]
    assign load_write = k_rise && !f_q.cycle_load_n &&
                        !f_q.read_write; // [R4] [R13] [R14]

    // Read address is loaded only by a read command; otherwise ignored.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_addr_q <= '0;
        end else if (load_read) begin
            rd_addr_q <= f_q.addr; // [R10] [R12]
        end
    end

    // Two-beat fetch: the array port gives a word per core cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetch_q <= 2'h0;
        end else if (load_read) begin
            fetch_q <= 2'h2;
        end else if (fetch_q != 2'h0) begin
            fetch_q <= fetch_q - 2'h1;
        end
    end

    // Fetched words land in the burst buffer in burst order.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_word0_q <= '0;
            rd_word1_q <= '0;
        end else if (fetch_q == 2'h2) begin
            rd_word0_q <= mem[rd_addr_q]; // [R15]
        end else if (fetch_q == 2'h1) begin
            rd_word1_q <= mem[next_in_burst(rd_addr_q)]; // [R10] [R15]
        end
    end

    // Output sequencer: word 0 on a true edge, word 1 on the complement.
    // A new read in the hold phase keeps the bus driven, saving a float.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_state_q <= RD_IDLE;
        end else if (load_read) begin
            rd_state_q <= RD_FIRST; // [R5]
        end else begin
            unique case (rd_state_q)
                RD_IDLE: begin
                    rd_state_q <= RD_IDLE;
                end
                RD_FIRST: begin
                    if (out_true_rise) begin
                        rd_state_q <= RD_SECOND;
                    end
                end
                RD_SECOND: begin
                    if (out_comp_rise) begin
                        rd_state_q <= RD_HOLD;
                    end
                end
                RD_HOLD: begin
                    if (out_true_rise) begin
                        rd_state_q <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // Data pins: registered words and an enable that is low while driving.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dq_out <= `DQ_RESET;
            dq_oe_n <= `OE_N_RESET;
        end else if (rd_state_q == RD_FIRST && out_true_rise &&
                     !load_read) begin
            dq_out <= rd_word0_q; // [R2]
            dq_oe_n <= 1'b0;
        end else if (rd_state_q == RD_SECOND && out_comp_rise) begin
            dq_out <= rd_word1_q; // [R2] [R5]
            dq_oe_n <= 1'b0;
        end else if (rd_state_q == RD_HOLD && out_true_rise &&
                     !load_read) begin
            dq_oe_n <= 1'b1; // [R3]
        end else if (rd_state_q == RD_IDLE) begin
            dq_oe_n <= 1'b1; // [R3]
        end
    end

    // Write address is loaded only by a write command.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_addr_q <= '0;
        end else if (load_write) begin
            wr_addr_q <= f_q.addr; // [R10] [R12]
        end
    end

    // Write sequencer: word 0 on the next complement edge, word 1 on the
    // following true edge, which may itself carry the next command.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_state_q <= WR_IDLE;
        end else begin
            unique case (wr_state_q)
                WR_IDLE: begin
                    if (load_write) begin
                        wr_state_q <= WR_FIRST; // [R5] [R14]
                    end
                end
                WR_FIRST: begin
                    if (kn_rise) begin
                        wr_state_q <= WR_SECOND;
                    end
                end
                WR_SECOND: begin
                    if (k_rise) begin
                        wr_state_q <= load_write ? WR_FIRST : WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= WR_IDLE;
                end
            endcase
        end
    end

    // Capture one burst word per input clock edge, with its own lanes.
    always_comb begin
        push_valid = 1'b0;
        push_word = '0;
        if (wr_state_q == WR_FIRST && kn_rise) begin
            push_valid = 1'b1; // [R1]
            push_word.addr = wr_addr_q; // [R15]
            push_word.data = f_q.dq; // [R1]
            push_word.lane_n = f_q.lane_n; // [R7]
        end else if (wr_state_q == WR_SECOND && k_rise) begin
            push_valid = 1'b1; // [R1]
            push_word.addr = next_in_burst(wr_addr_q); // [R10] [R15]
            push_word.data = f_q.dq; // [R1]
            push_word.lane_n = f_q.lane_n; // [R7]
        end
    end

    // Reads own the array port; writes drain only while no fetch runs.
    // A read of a word still queued here returns the older array value.
    assign drain_ready = (fetch_q == 2'h0) && !load_read;

    sync_fifo #(
        .WIDTH($bits(wr_word_s)),
        .DEPTH(`WBUF_DEPTH)
    ) write_buffer (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_word)
    );

    // A full buffer is reported; a word pushed then is lost.
    assign write_buffer_full = !push_ready;

    // Lane-masked array write: unselected lanes keep their old contents.
    always_ff @(posedge core_clk) begin
        if (drain_valid && drain_ready) begin
            for (int i = 0; i < `LANES; i++) begin
                if (!drain_word.lane_n[i]) begin // [R6] [R8]
                    mem[drain_word.addr][i*`LANE_W +: `LANE_W] <=
                        drain_word.data[i*`LANE_W +: `LANE_W]; // [R6]
                end
            end
        end
    end

endmodule : ddr_burst2_sram_port

`default_nettype wire

// >>> ddr_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_port_map.svh"

module ddr_port_checker (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Controller pins.
    input wire logic k_clk,
    input wire logic k_clk_n,
    input wire logic c_clk,
    input wire logic c_clk_n,
    input wire logic single_clock_mode,
    input wire logic cycle_load_n,
    input wire logic read_write,
    // Device outputs.
    input wire logic [`DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic write_buffer_full
);
    logic out_t, out_c, t_q, c_q, k_q, rd_pend_q;
    logic [3:0] since_t_q, since_c_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Output clocks follow the input clocks in single clock mode.
    assign out_t = single_clock_mode ? k_clk : c_clk;
    assign out_c = single_clock_mode ? k_clk_n : c_clk_n;

    // Age of the latest raw output clock rises; saturates so it never wraps.
    always_ff @(posedge core_clk) begin
        t_q <= out_t;
        c_q <= out_c;
        if (rst) since_t_q <= 4'hF;
        else if (out_t && !t_q) since_t_q <= 4'h0;
        else if (since_t_q != 4'hF) since_t_q <= since_t_q + 4'h1;
        if (rst) since_c_q <= 4'hF;
        else if (out_c && !c_q) since_c_q <= 4'h0;
        else if (since_c_q != 4'hF) since_c_q <= since_c_q + 4'h1;
    end

    // Raw pins lead the filtered image, so a read is known here first.
    always_ff @(posedge core_clk) begin
        k_q <= k_clk;
        if (rst) rd_pend_q <= 1'b0;
        else if (k_clk && !k_q && !cycle_load_n && read_write) rd_pend_q <= 1'b1;
        else if (!dq_oe_n) rd_pend_q <= 1'b0;
    end

    property p_reset_idle;
        $fell(rst) |-> (dq_out == 36'h0 && !write_buffer_full) ##0 dq_oe_n [*3];
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("outputs not idle after reset");

    property p_drive_after_true;
        $fell(dq_oe_n) |-> since_t_q <= 4'h6;
    endproperty
    a_drive_after_true: assert property (p_drive_after_true)
        else $error("first word without output true edge");

    property p_drive_needs_read;
        $fell(dq_oe_n) |-> $past(rd_pend_q, 2);
    endproperty
    a_drive_needs_read: assert property (p_drive_needs_read)
        else $error("outputs driven without a loaded read");

    property p_burst_hold;
        $fell(dq_oe_n) |=> !dq_oe_n [*2];
    endproperty
    a_burst_hold: assert property (p_burst_hold)
        else $error("read burst cut short");

    property p_release_after_true;
        $rose(dq_oe_n) |-> since_t_q <= 4'h6;
    endproperty
    a_release_after_true: assert property (p_release_after_true)
        else $error("outputs released without output true edge");

    property p_word_after_edge;
        $changed(dq_out) && !dq_oe_n && !$past(dq_oe_n)
            |-> since_c_q <= 4'h6 || since_t_q <= 4'h6;
    endproperty
    a_word_after_edge: assert property (p_word_after_edge)
        else $error("read word changed without output edge");

    property p_quiet_stable;
        !dq_oe_n && since_t_q > 4'h6 && since_c_q > 4'h6 |-> $stable(dq_out);
    endproperty
    a_quiet_stable: assert property (p_quiet_stable)
        else $error("read word moved between output edges");

    property p_idle_after_release;
        $rose(dq_oe_n) |=> dq_oe_n [*2];
    endproperty
    a_idle_after_release: assert property (p_idle_after_release)
        else $error("outputs driven again too soon");

endmodule : ddr_port_checker

bind ddr_burst2_sram_port ddr_port_checker u_chk (.core_clk, .rst, .k_clk,
    .k_clk_n, .c_clk, .c_clk_n, .single_clock_mode, .cycle_load_n,
    .read_write, .dq_out, .dq_oe_n, .write_buffer_full);

`default_nettype wire

// >>> mem_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_port_map.svh"

module mem_ctrl_model
    import ddr_port_pkg::*;
(
    // Core clock.
    input wire logic core_clk,
    // Clocks and command towards the port.
    output logic k_clk,
    output logic k_clk_n,
    output logic c_clk,
    output logic c_clk_n,
    output logic cycle_load_n,
    output logic read_write,
    output logic [`ADDR_W-2:0] addr_hi,
    output logic burst_lsb_addr,
    // Data towards and from the port.
    output logic [`LANES-1:0] lane_write_enable_n,
    output logic [`DATA_W-1:0] dq_in,
    input wire logic [`DATA_W-1:0] dq_out,
    input wire logic dq_oe_n
);
    // Clocks stand still low between frames.
    initial begin
        {k_clk, k_clk_n, c_clk, c_clk_n} = 4'h0;
        cycle_load_n = 1'b1;
        read_write = 1'b1;
        {addr_hi, burst_lsb_addr} = 19'h0;
        lane_write_enable_n = 4'hF;
        dq_in = 36'h0;
    end

    // Four cycles per level, since the port filters pins over three.
    task automatic hold();
        repeat (4) @(negedge core_clk);
    endtask : hold

    // Loads one command; the address floats to a changed value afterwards.
    task automatic cmd(input addr_t a, input logic rd);
        cycle_load_n = 1'b0;
        read_write = rd;
        {addr_hi, burst_lsb_addr} = a;
        hold();
        k_clk = 1'b1;
        hold();
        k_clk = 1'b0;
        cycle_load_n = 1'b1;
        {addr_hi, burst_lsb_addr} = ~a;
        hold();
    endtask : cmd

    task automatic wr(input addr_t a, input data_t w0, input lane_t l0,
                      input data_t w1, input lane_t l1);
        cmd(a, 1'b0);
        dq_in = w0;
        lane_write_enable_n = l0;
        hold();
        k_clk_n = 1'b1;
        hold();
        k_clk_n = 1'b0;
        dq_in = w1;
        lane_write_enable_n = l1;
        hold();
        k_clk = 1'b1;
        hold();
        k_clk = 1'b0;
        dq_in = ~w1;
        lane_write_enable_n = 4'hF;
        hold();
    endtask : wr

    // Clock edges with the load strobe high must change nothing.
    task automatic stray(input addr_t a, input data_t d);
        read_write = 1'b0;
        {addr_hi, burst_lsb_addr} = a;
        dq_in = d;
        lane_write_enable_n = 4'h0;
        hold();
        k_clk = 1'b1;
        hold();
        k_clk = 1'b0;
        hold();
        k_clk_n = 1'b1;
        hold();
        k_clk_n = 1'b0;
        hold();
    endtask : stray

    task automatic out_clk(input logic sgl, input logic comp, input logic v);
        if (sgl && !comp) k_clk = v;
        else if (sgl) k_clk_n = v;
        else if (!comp) c_clk = v;
        else c_clk_n = v;
    endtask : out_clk

    task automatic out_edge(input logic sgl, input logic comp,
                            output data_t q, output logic oe_n);
        out_clk(sgl, comp, 1'b1);
        hold();
        hold();
        // A released bus has no keeper here, so it shows the inverse.
        q = dq_oe_n ? ~dq_out : dq_out;
        oe_n = dq_oe_n;
        out_clk(sgl, comp, 1'b0);
        hold();
    endtask : out_edge

    task automatic rd(input addr_t a, input logic sgl, output data_t r0,
                      output data_t r1, output logic [2:0] oe_n);
        data_t spare;
        cmd(a, 1'b1);
        out_edge(sgl, 1'b0, r0, oe_n[2]);
        out_edge(sgl, 1'b1, r1, oe_n[1]);
        out_edge(sgl, 1'b0, spare, oe_n[0]);
    endtask : rd

endmodule : mem_ctrl_model

`default_nettype wire

// >>> tb_ddr_burst2_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddr_port_map.svh"

module tb_ddr_burst2_sram_port;
    import ddr_port_pkg::*;
    localparam addr_t ADR = 19'h2_A5C4;
    localparam data_t WA = 36'h1_2345_6789;
    localparam data_t WB = 36'hA_BCDE_F012;
    localparam data_t WC = 36'h5_5AA5_3CC3;
    logic core_clk, rst, single_clock_mode, k_clk, k_clk_n, c_clk, c_clk_n;
    logic cycle_load_n, read_write, burst_lsb_addr, dq_oe_n;
    logic write_buffer_full;
    logic [`ADDR_W-2:0] addr_hi;
    lane_t lane_write_enable_n;
    data_t dq_in, dq_out, r0, r1, e0, e1;
    logic [2:0] oe;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    ddr_burst2_sram_port dut (.core_clk, .rst, .k_clk, .k_clk_n, .c_clk,
        .c_clk_n, .single_clock_mode, .cycle_load_n, .read_write, .addr_hi,
        .burst_lsb_addr, .lane_write_enable_n, .dq_in, .dq_out, .dq_oe_n,
        .write_buffer_full);

    mem_ctrl_model u_ctrl (.core_clk, .k_clk, .k_clk_n, .c_clk, .c_clk_n,
        .cycle_load_n, .read_write, .addr_hi, .burst_lsb_addr,
        .lane_write_enable_n, .dq_in, .dq_out, .dq_oe_n);

    // Free running core clock.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // A hung handshake ends the run well after the few hundred cycles needed.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    task automatic check(input data_t seen, input data_t exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    // Keeps the stored lanes whose active-low select is high.
    function automatic data_t merge(input data_t old, input data_t nw,
                                    input lane_t ln);
        data_t m;
        m = old;
        for (int i = 0; i < `LANES; i++) begin
            if (!ln[i]) m[i*`LANE_W +: `LANE_W] = nw[i*`LANE_W +: `LANE_W];
        end
        return m;
    endfunction : merge

    task automatic t_reset();
        check(dq_oe_n, 1'b1);
        check(dq_out, 36'h0);
        check(write_buffer_full, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_basic();
        u_ctrl.wr(ADR, WA, 4'h0, WB, 4'h0);
        check(write_buffer_full, 1'b0);
        u_ctrl.rd(ADR, 1'b0, r0, r1, oe);
        check(r0, WA);
        check(r1, WB);
        check(oe, 3'h1);
        u_ctrl.rd(ADR ^ 19'h1, 1'b0, r0, r1, oe);
        check(r0, WB);
        check(r1, WA);
        $display("test basic done");
    endtask : t_basic

    // Each word carries its own selects; the two patterns are complements.
    task automatic t_lanes();
        e0 = merge(WA, WC, 4'hA);
        e1 = merge(WB, WC, 4'h5);
        u_ctrl.wr(ADR, WC, 4'hA, WC, 4'h5);
        u_ctrl.rd(ADR, 1'b0, r0, r1, oe);
        check(r0, e0);
        check(r1, e1);
        check(r0[8:0], WC[8:0]);
        $display("test lanes done");
    endtask : t_lanes

    task automatic t_ignore();
        u_ctrl.stray(ADR, ~WC);
        u_ctrl.stray(ADR ^ 19'h1, WA);
        u_ctrl.rd(ADR, 1'b0, r0, r1, oe);
        check(r0, e0);
        check(r1, e1);
        $display("test ignore done");
    endtask : t_ignore

    task automatic t_single();
        single_clock_mode = 1'b1;
        u_ctrl.rd(ADR ^ 19'h1, 1'b1, r0, r1, oe);
        check(r0, e1);
        check(r1, e0);
        check(oe, 3'h1);
        single_clock_mode = 1'b0;
        $display("test single done");
    endtask : t_single

    // Reset is released on a falling edge, clear of the sampling edge.
    initial begin
        rst = 1'b1;
        single_clock_mode = 1'b0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_reset();
        t_basic();
        t_lanes();
        t_ignore();
        t_single();
        wrap_up();
    end

endmodule : tb_ddr_burst2_sram_port

`default_nettype wire
